// File: logic/slot_seq_defs.svh
// Constants of the slot sequencer: register offsets, field positions,
// time figures and their cycle counts at the 40 MHz reference clock.
// Notes on behaviour
// [RQ1] Output slot code 0000 leaves that enable output unassigned and never driven.
// [RQ2] Codes 0001 to 1100 place the output in slot code minus one.
// [RQ3] Codes 1101 to 1111 are reserved and treated as unassigned.
// [RQ4] Power-up fault timeout, bits 1:0: 25, 50, 100 or 200 ms.
// [RQ5] Power-down fault timeout, bits 3:2: 25, 50, 100 or 200 ms.
// [RQ6] Bits 7:4 each enable the pulldown on tracking sense inputs 1 to 4.
// [RQ7] Autoretry timeout, bits 2:0, uses the eight-step delay table.
// [RQ8] Recovery bit 3: 0 retries after the timeout, 1 latches outputs off.
// [RQ9] Slew field bits 5:4 sets ramp 800, 400, 200 or 100 V/s.
// [RQ10] Deglitch field bits 7:6 needs 2, 4, 8 or 16 conversions.
// [RQ11] Slot 0 delay from bits 2:0, slot 1 from bits 5:3, first byte.
// [RQ12] Slot 2 delay: first byte bits 7:6 low, second byte bit 0 high.
// [RQ13] Slot 3 delay from bits 3:1, slot 4 from bits 6:4, second byte.
// [RQ14] Slot 5 delay: second byte bit 7 low, third byte bits 1:0 high.
// [RQ15] Slot 6 delay from bits 4:2, slot 7 from bits 7:5, third byte.
// [RQ16] Slot 8 delay from bits 2:0, slot 9 from bits 5:3, fourth byte.
// [RQ17] Slot 10 delay: fourth byte bits 7:6 low, fifth byte bit 0 high.
// [RQ18] Slot 11 delay from fifth byte bits 3:1; bits 7:5 unused.
// [RQ19] Reverse bit set: power down slot by slot in reverse order.
// [RQ20] Reverse bit clear: all assigned outputs drop in the same cycle.
// [RQ21] Delay codes map 20 us, 12.5 to 400 ms doubling, then 1.6 s.
// [RQ22] Power-up asserts slot 0 first, then each higher slot up to 11.
// [RQ23] Reverse power-down waits each slot's delay before the next lower slot.
// [RQ24] Slot monitors must pass undervoltage within power-up timeout or fault.
// [RQ25] Fault timeout restarts at each slot start, cleared when slot passes.
`ifndef SLOT_SEQ_DEFS_SVH
`define SLOT_SEQ_DEFS_SVH

// Register offsets
`define OFS_TIMEOUT_PD   8'h4e
`define OFS_RECOVERY     8'h4f
`define OFS_DLY_FIRST    8'h50
`define OFS_DLY_SECOND   8'h51
`define OFS_DLY_THIRD    8'h52
`define OFS_DLY_FOURTH   8'h53
`define OFS_DLY_LAST     8'h54
`define OFS_SLOT_BASE    8'h5e
`define CFG_RESET        8'h00
`define DLY_LAST_MASK    8'h1f

// Field positions
`define BIT_PD_ENA_LO    4
`define BIT_RECOVERY     3
`define BIT_REVERSE      4

// Times in microseconds and derived cycle counts
`define CLK_MHZ          40
`define US2CYC(t)        ((t) * `CLK_MHZ)
`define T_20US           20
`define T_12M5_US        12500
`define T_25MS_US        25000
`define T_50MS_US        50000
`define T_100MS_US       100000
`define T_200MS_US       200000
`define T_400MS_US       400000
`define T_1S6_US         1600000
`define CNT_W            27

`endif

// File: logic/seq_cfg_pkg.sv
// Types shared by the slot sequencer modules.
// Assumes the constants header is compiled alongside.
package seq_cfg_pkg;

  typedef logic [26:0] cyc_t;
  typedef logic [3:0]  slot_code_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_CHECK,
    ST_DELAY,
    ST_ON,
    ST_DOWN,
    ST_FAULT,
    ST_RETRY
  } seq_state_t;

endpackage

// File: logic/timer_if.sv
// Carrier between the sequencer and its cycle timer.
// Assumes both ends share ref_clk.
interface timer_if;
  logic                load;
  seq_cfg_pkg::cyc_t   cycles;
  logic                done;
  logic                busy;

  modport ctrl (output load, output cycles, input done, input busy);
  modport tmr  (input load, input cycles, output done, output busy);
endinterface

// File: logic/seq_timer.sv
// Loadable down counter; done pulses exactly cycles clocks after load.
// Assumes a load of zero cycles is never requested.
module seq_timer
(
  // Clock and reset
  input  wire logic   ref_clk,
  input  wire logic   rst,
  // Control carrier
  timer_if.tmr        t
);

  seq_cfg_pkg::cyc_t cnt_q;

  // Done in the last counted cycle
  assign t.done = (cnt_q == seq_cfg_pkg::cyc_t'(1));
  assign t.busy = (cnt_q != '0);

  // Load wins over counting
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cnt_q <= '0;
    else if (t.load)
      cnt_q <= t.cycles;
    else if (t.busy)
      cnt_q <= cnt_q - seq_cfg_pkg::cyc_t'(1);
  end

endmodule

// File: logic/slot_map.sv
// Turns per-output slot codes into a per-slot mask of enable outputs.
// Assumes codes are stable register values.
module slot_map #(
  parameter int NUM_OUT = 12
)
(
  // Slot code per output
  input  wire logic [NUM_OUT*4-1:0] codes,
  // One mask per slot 0..11, bit o set when output o sits there
  output logic [11:0][NUM_OUT-1:0]  slot_mask
);

  for (genvar o = 0; o < NUM_OUT; o++)
  begin : g_out
    wire [3:0] code  = codes[o*4 +: 4];
    // Only 1..12 assign a slot; 0 and 13..15 leave the output idle
    wire       valid = (code != 4'h0) && (code <= 4'hc);   // see [RQ1] see [RQ3]
    wire [3:0] slot  = code - 4'h1;                         // see [RQ2]
    for (genvar s = 0; s < 12; s++)
    begin : g_slot
      assign slot_mask[s][o] = valid && (slot == 4'(s));
    end
  end

endmodule

// File: logic/slot_sequencer_config.sv
// Slot power sequencer core: configuration bytes, delay decode and
// the power-up / power-down sequence of the enable outputs.
// Assumes config bytes arrive on a byte write port from storage or host,
// and that per-slot monitor results come from the voltage monitor.
`include "slot_seq_defs.svh"

module slot_sequencer_config #(
  parameter int NUM_OUT = 12,
  parameter logic [26:0] DLY_CYC [8] = '{
    27'(`US2CYC(`T_20US)),     27'(`US2CYC(`T_12M5_US)),
    27'(`US2CYC(`T_25MS_US)),  27'(`US2CYC(`T_50MS_US)),
    27'(`US2CYC(`T_100MS_US)), 27'(`US2CYC(`T_200MS_US)),
    27'(`US2CYC(`T_400MS_US)), 27'(`US2CYC(`T_1S6_US))},
  parameter logic [26:0] TMO_CYC [4] = '{
    27'(`US2CYC(`T_25MS_US)),  27'(`US2CYC(`T_50MS_US)),
    27'(`US2CYC(`T_100MS_US)), 27'(`US2CYC(`T_200MS_US))}
)
(
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Configuration byte port
  input  wire logic [7:0]         cfg_addr,
  input  wire logic               cfg_we,
  input  wire logic [7:0]         cfg_wdata,
  output logic [7:0]              cfg_rdata,
  // Sequence control and monitor results
  input  wire logic               power_enable,
  input  wire logic [12:0]        mon_slot_ok,
  // Supply enables and tracking pulldowns
  output logic [NUM_OUT-1:0]      en_out,
  output logic [3:0]              pulldown_en,
  // Decoded settings for the tracking and monitor logic
  output logic [9:0]              slew_vps,
  output logic [4:0]              deglitch_conv,
  output logic [26:0]             pd_timeout_cyc,
  // Status
  output logic                    fault_pulse,
  output logic                    fault_latched,
  output logic                    seq_done,
  output logic [3:0]              cur_slot
);

  localparam int SLOT_BYTES = (NUM_OUT + 1) / 2;

  // Configuration registers
  logic [7:0] tmo_q;
  logic [7:0] rec_q;
  logic [7:0] dly_q [5];
  logic [7:0] slot_q [SLOT_BYTES];

  // Sequencer state
  seq_cfg_pkg::seq_state_t st_q;
  seq_cfg_pkg::seq_state_t st_d;
  logic [3:0]              slot_q_idx;
  logic [3:0]              slot_d_idx;
  logic [NUM_OUT-1:0]      en_q;
  logic [NUM_OUT-1:0]      en_d;
  logic                    fault_q;
  logic                    fault_d;
  logic                    flt_pulse_q;
  logic                    flt_pulse_d;

  timer_if tmr ();

  // Address decode
  wire [4:0] dly_hit;
  wire [SLOT_BYTES-1:0] slot_hit;
  wire hit_tmo = (cfg_addr == `OFS_TIMEOUT_PD);
  wire hit_rec = (cfg_addr == `OFS_RECOVERY);

  for (genvar i = 0; i < 5; i++)
  begin : g_dly_hit
    assign dly_hit[i] = (cfg_addr == 8'(`OFS_DLY_FIRST + i));
  end

  for (genvar i = 0; i < SLOT_BYTES; i++)
  begin : g_slot_hit
    assign slot_hit[i] = (cfg_addr == 8'(`OFS_SLOT_BASE + i));
  end

  // Config byte writes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      tmo_q <= `CFG_RESET;
      rec_q <= `CFG_RESET;
      dly_q <= '{default: `CFG_RESET};
    end
    else if (cfg_we)
    begin
      if (hit_tmo)
        tmo_q <= cfg_wdata;
      if (hit_rec)
        rec_q <= cfg_wdata;
      for (int i = 0; i < 4; i++)
        if (dly_hit[i])
          dly_q[i] <= cfg_wdata;
      // Bits 7:5 of the last delay byte are not stored
      if (dly_hit[4])
        dly_q[4] <= cfg_wdata & `DLY_LAST_MASK;   // see [RQ18]
    end
  end

  // Slot assignment bytes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      slot_q <= '{default: `CFG_RESET};
    else if (cfg_we)
      for (int i = 0; i < SLOT_BYTES; i++)
        if (slot_hit[i])
          slot_q[i] <= cfg_wdata;
  end

  // Read mux; unmapped offsets read zero
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    if (hit_tmo)
      rd_mux = tmo_q;
    if (hit_rec)
      rd_mux = rec_q;
    for (int i = 0; i < 5; i++)
      if (dly_hit[i])
        rd_mux = dly_q[i];
    for (int i = 0; i < SLOT_BYTES; i++)
      if (slot_hit[i])
        rd_mux = slot_q[i];
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cfg_rdata <= 8'h00;
    else
      cfg_rdata <= rd_mux;
  end

  // Slot codes flattened for the mapper
  logic [NUM_OUT*4-1:0]      codes;
  logic [11:0][NUM_OUT-1:0]  slot_mask;

  for (genvar o = 0; o < NUM_OUT; o++)
  begin : g_codes
    assign codes[o*4 +: 4] = slot_q[o/2][(o%2)*4 +: 4];
  end

  slot_map #(
    .NUM_OUT   (NUM_OUT)
  ) u_map (
    .codes     (codes),
    .slot_mask (slot_mask)
  );

  // Per-slot delay codes, packed across five bytes
  wire [2:0] sd [12];
  assign sd[0]  = dly_q[0][2:0];                  // see [RQ11]
  assign sd[1]  = dly_q[0][5:3];                  // see [RQ11]
  assign sd[2]  = {dly_q[1][0], dly_q[0][7:6]};   // see [RQ12]
  assign sd[3]  = dly_q[1][3:1];                  // see [RQ13]
  assign sd[4]  = dly_q[1][6:4];                  // see [RQ13]
  assign sd[5]  = {dly_q[2][1:0], dly_q[1][7]};   // see [RQ14]
  assign sd[6]  = dly_q[2][4:2];                  // see [RQ15]
  assign sd[7]  = dly_q[2][7:5];                  // see [RQ15]
  assign sd[8]  = dly_q[3][2:0];                  // see [RQ16]
  assign sd[9]  = dly_q[3][5:3];                  // see [RQ16]
  assign sd[10] = {dly_q[4][0], dly_q[3][7:6]};   // see [RQ17]
  assign sd[11] = dly_q[4][3:1];                  // see [RQ18]

  // Delay table lookup, shared by slots and autoretry
  function automatic logic [26:0] dly_cycles(input logic [2:0] code);
    return DLY_CYC[code];   // see [RQ21]
  endfunction

  // Decoded settings
  wire        reverse   = dly_q[4][`BIT_REVERSE];
  wire        latch_off = rec_q[`BIT_RECOVERY];
  wire [26:0] pu_tmo    = TMO_CYC[tmo_q[1:0]];   // see [RQ4]
  wire [26:0] retry_cyc = dly_cycles(rec_q[2:0]);   // see [RQ7]
  wire [2:0]  cur_code  = (slot_q_idx < 4'd12) ? sd[slot_q_idx] : sd[11];
  wire [26:0] cur_dly   = dly_cycles(cur_code);
  wire [3:0]  dn_slot   = slot_q_idx - 4'd1;
  wire [26:0] dn_dly    = dly_cycles(sd[dn_slot]);

  // Settings fed out to tracking and monitor logic
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pulldown_en    <= 4'h0;
      slew_vps       <= 10'h000;
      deglitch_conv  <= 5'h00;
      pd_timeout_cyc <= '0;
    end
    else
    begin
      pulldown_en    <= tmo_q[7:`BIT_PD_ENA_LO];   // see [RQ6]
      slew_vps       <= 10'(800 >> rec_q[5:4]);    // see [RQ9]
      deglitch_conv  <= 5'(2 << rec_q[7:6]);       // see [RQ10]
      pd_timeout_cyc <= TMO_CYC[tmo_q[3:2]];       // see [RQ5]
    end
  end

  // Sequencer next state
  always_comb
  begin
    st_d        = st_q;
    slot_d_idx  = slot_q_idx;
    en_d        = en_q;
    fault_d     = fault_q;
    flt_pulse_d = 1'b0;
    tmr.load    = 1'b0;
    tmr.cycles  = cur_dly;
    unique case (st_q)
      seq_cfg_pkg::ST_OFF:
      begin
        en_d = '0;
        if (power_enable && !fault_q)
        begin
          // Slot 0 outputs come on before its own delay
          slot_d_idx = 4'd0;
          en_d       = slot_mask[0];              // see [RQ22]
          tmr.load   = 1'b1;
          tmr.cycles = dly_cycles(sd[0]);
          st_d       = seq_cfg_pkg::ST_DELAY;
        end
        if (!power_enable)
          fault_d = 1'b0;
      end
      seq_cfg_pkg::ST_CHECK:
      begin
        // Monitors of this slot must pass before the timeout ends
        if (!power_enable)
          st_d = seq_cfg_pkg::ST_ON;
        else if (mon_slot_ok[slot_q_idx])
        begin
          tmr.load   = 1'b1;                      // see [RQ25]
          tmr.cycles = cur_dly;
          st_d       = seq_cfg_pkg::ST_DELAY;
        end
        else if (tmr.done)
        begin
          en_d        = '0;                       // see [RQ24]
          flt_pulse_d = 1'b1;
          fault_d     = latch_off;
          st_d        = latch_off ? seq_cfg_pkg::ST_FAULT : seq_cfg_pkg::ST_RETRY;
          tmr.load    = !latch_off;               // see [RQ8]
          tmr.cycles  = retry_cyc;
        end
      end
      seq_cfg_pkg::ST_DELAY:
      begin
        if (!power_enable)
          st_d = seq_cfg_pkg::ST_ON;
        else if (tmr.done)
        begin
          // Slots 1..11 assert at the end of their delay
          if (slot_q_idx != 4'd0 && slot_q_idx < 4'd12)
            en_d = en_q | slot_mask[slot_q_idx];  // see [RQ22]
          if (slot_q_idx == 4'd12)
            st_d = seq_cfg_pkg::ST_ON;
          else
          begin
            slot_d_idx = slot_q_idx + 4'd1;
            tmr.load   = 1'b1;                    // see [RQ25]
            tmr.cycles = pu_tmo;
            st_d       = seq_cfg_pkg::ST_CHECK;
          end
        end
      end
      seq_cfg_pkg::ST_ON:
      begin
        if (!power_enable)
        begin
          if (reverse)
          begin
            // Drop slot 11 now, then wait its delay
            slot_d_idx = 4'd11;
            en_d       = en_q & ~slot_mask[11];   // see [RQ19]
            tmr.load   = 1'b1;
            tmr.cycles = dly_cycles(sd[11]);      // see [RQ23]
            st_d       = seq_cfg_pkg::ST_DOWN;
          end
          else
          begin
            en_d = '0;                            // see [RQ20]
            st_d = seq_cfg_pkg::ST_OFF;
          end
        end
      end
      seq_cfg_pkg::ST_DOWN:
      begin
        if (tmr.done)
        begin
          if (slot_q_idx == 4'd0)
            st_d = seq_cfg_pkg::ST_OFF;
          else
          begin
            slot_d_idx = dn_slot;
            en_d       = en_q & ~slot_mask[dn_slot];   // see [RQ19]
            tmr.load   = 1'b1;
            tmr.cycles = dn_dly;                       // see [RQ23]
          end
        end
      end
      seq_cfg_pkg::ST_FAULT:
      begin
        // Latched off until enable is withdrawn
        en_d = '0;
        if (!power_enable)
        begin
          fault_d = 1'b0;
          st_d    = seq_cfg_pkg::ST_OFF;
        end
      end
      seq_cfg_pkg::ST_RETRY:
      begin
        en_d = '0;
        if (tmr.done)
          st_d = seq_cfg_pkg::ST_OFF;             // see [RQ8]
      end
      default:
      begin
        en_d = '0;
        st_d = seq_cfg_pkg::ST_OFF;
      end
    endcase
  end

  seq_timer u_tmr (
    .ref_clk (ref_clk),
    .rst     (rst),
    .t       (tmr.tmr)
  );

  // Sequencer registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_q        <= seq_cfg_pkg::ST_OFF;
      slot_q_idx  <= 4'd0;
      en_q        <= '0;
      fault_q     <= 1'b0;
      flt_pulse_q <= 1'b0;
    end
    else
    begin
      st_q        <= st_d;
      slot_q_idx  <= slot_d_idx;
      en_q        <= en_d;
      fault_q     <= fault_d;
      flt_pulse_q <= flt_pulse_d;
    end
  end

  // Status outputs
  assign en_out        = en_q;
  assign fault_pulse   = flt_pulse_q;
  assign fault_latched = fault_q;
  assign seq_done      = (st_q == seq_cfg_pkg::ST_ON);
  assign cur_slot      = slot_q_idx;

endmodule

// File: verif/slot_seq_chk.sv
// Concurrent checks on the ports of the slot sequencer core.
// Assumes one clock and the timeout table handed on through the bind.
module slot_seq_chk #(
  parameter int          NUM_OUT = 12,
  parameter logic [26:0] TMO_CYC [4] = '{default: 27'h2}
)
(
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               rst,
  // Config port
  input wire logic [7:0]         cfg_addr,
  input wire logic               cfg_we,
  input wire logic [7:0]         cfg_wdata,
  input wire logic [7:0]         cfg_rdata,
  // Control and outputs
  input wire logic               power_enable,
  input wire logic [NUM_OUT-1:0] en_out,
  input wire logic [3:0]         pulldown_en,
  input wire logic [9:0]         slew_vps,
  input wire logic [4:0]         deglitch_conv,
  input wire logic [26:0]        pd_timeout_cyc,
  input wire logic               fault_pulse,
  input wire logic               fault_latched,
  input wire logic               seq_done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] r4e_q;
  logic [7:0] r4f_q;
  logic       rev_q;
  logic [1:0] age_q;
  // Write strobes of the watched registers
  wire wr_4e = cfg_we && cfg_addr == 8'h4e;
  wire wr_4f = cfg_we && cfg_addr == 8'h4f;
  wire wr_54 = cfg_we && cfg_addr == 8'h54;
  // Shadow settings; age counts edges since the last settings write, stopping at two
  always_ff @(posedge ref_clk)
  begin
    r4e_q <= rst ? 8'h00 : (wr_4e ? cfg_wdata : r4e_q);
    r4f_q <= rst ? 8'h00 : (wr_4f ? cfg_wdata : r4f_q);
    rev_q <= rst ? 1'b0 : (wr_54 ? cfg_wdata[4] : rev_q);
    age_q <= (rst || wr_4e || wr_4f) ? 2'h0 : age_q + {1'b0, age_q != 2'h2};
  end
  rsvd_bits_a:
    assert property (cfg_addr == 8'h54 |=> cfg_rdata[7:5] == 3'h0) else $error("unused bits read");
  pulldown_wr_a:
    assert property (wr_4e ##1 !wr_4e |=> pulldown_en == r4e_q[7:4])
      else $error("pulldown mismatch");
  pd_timeout_a:
    assert property (age_q == 2'h2 |-> pd_timeout_cyc == TMO_CYC[r4e_q[3:2]])
      else $error("power-down timeout decode");
  slew_decode_a:
    assert property (age_q == 2'h2 |-> slew_vps == (10'h320 >> r4f_q[5:4])) else $error("slew");
  deglitch_decode_a:
    assert property (age_q == 2'h2 |-> deglitch_conv == (5'h02 << r4f_q[7:6]))
      else $error("deglitch decode");
  fault_single_a:
    assert property (fault_pulse |=> !fault_pulse) else $error("fault pulse too long");
  no_rise_a:
    assert property (!power_enable ##1 !power_enable |=> (en_out & ~$past(en_out)) == '0)
      else $error("enable rose while disabled");
  all_off_a:
    assert property ($fell(power_enable) && !rev_q |-> ##[1:2] en_out == '0)
      else $error("simultaneous power-down late");
  done_hold_a:
    assert property (seq_done && power_enable |=> $stable(en_out)) else $error("enables moved");
  latch_clear_a:
    assert property (fault_latched && !power_enable |=> !fault_latched) else $error("latch held");
  latch_off_a:
    assert property (fault_latched [*2] |-> en_out == '0) else $error("latched but driving");
  cover property (seq_done && power_enable);
  cover property ($rose(fault_latched));
  cover property ($fell(power_enable) && rev_q);
endmodule

bind slot_sequencer_config slot_seq_chk #(.NUM_OUT(NUM_OUT), .TMO_CYC(TMO_CYC)) chk (
  .ref_clk, .rst, .cfg_addr, .cfg_we, .cfg_wdata, .cfg_rdata, .power_enable, .en_out,
  .pulldown_en, .slew_vps, .deglitch_conv, .pd_timeout_cyc, .fault_pulse, .fault_latched,
  .seq_done);

// File: verif/supply_model.sv
// Model of the external supplies switched by the enable outputs.
// Assumes output o sits in slot o; a vacant slot reads as already good.
module supply_model #(
  parameter int RAMP = 3
)
(
  // Clock
  input  wire logic        ref_clk,
  // Enables and test controls
  input  wire logic [11:0] en_out,
  input  wire logic [11:0] vacant,
  input  wire logic [12:0] hold_low,
  // Monitor results per slot
  output logic [12:0]      mon_slot_ok
);
  logic [11:0] up_q [RAMP];
  // A supply is good RAMP cycles after enable and drops at once
  always_ff @(posedge ref_clk)
  begin
    up_q[0] <= en_out | vacant;
    for (int i = 1; i < RAMP; i++)
      up_q[i] <= up_q[i-1] & (en_out | vacant);
  end
  // Slot n watches the supply of slot n-1; hold_low forces a stuck rail
  assign mon_slot_ok = {up_q[RAMP-1] & (en_out | vacant), 1'b0} & ~hold_low;
endmodule

// File: verif/slot_sequencer_config_tb_top.sv
// Bench of the slot sequencer core: registers, decodes, sequencing, faults.
// Assumes shortened delay and timeout tables and the supply model.
module slot_sequencer_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [26:0] DLY [8] = '{27'h2, 27'h8, 27'he, 27'h14, 27'h1a, 27'h20, 27'h26, 27'h2c};
  localparam logic [26:0] TMO [4] = '{27'h14, 27'h1e, 27'h28, 27'h32};
  logic        ref_clk, rst, cfg_we, power_enable, fault_pulse, fault_latched, seq_done;
  logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
  logic [12:0] mon_slot_ok, hold_low;
  logic [11:0] en_out, vacant;
  logic [3:0]  pulldown_en, cur_slot;
  logic [9:0]  slew_vps;
  logic [4:0]  deglitch_conv;
  logic [26:0] pd_timeout_cyc;
  int          failures, checks_done, k, t0, t_up [12], t_dn [12];
  int          now = 0;
  logic [2:0]  dc [12] = '{3'h1, 3'h4, 3'h6, 3'h2, 3'h7, 3'h3, 3'h5, 3'h0, 3'h6, 3'h3, 3'h5, 3'h4};
  wire  [1:0]  flags = {fault_pulse, seq_done};

  slot_sequencer_config #(.NUM_OUT(12), .DLY_CYC(DLY), .TMO_CYC(TMO)) dut (
    .ref_clk, .rst, .cfg_addr, .cfg_we, .cfg_wdata, .cfg_rdata, .power_enable, .mon_slot_ok,
    .en_out, .pulldown_en, .slew_vps, .deglitch_conv, .pd_timeout_cyc, .fault_pulse,
    .fault_latched, .seq_done, .cur_slot);
  supply_model #(.RAMP(3)) supplies (.ref_clk, .en_out, .vacant, .hold_low, .mon_slot_ok);

  // Clock and cycle count
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) now <= now + 1;

  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic cmp(input logic [26:0] got, input logic [26:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_we = 1'b1;
    tick();
    cfg_we = 1'b0;
    tick(); // Idle edge between writes
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cfg_addr = a;
    tick();
    cmp(27'(cfg_rdata), 27'(exp), "register read");
  endtask
  // Bounded waits; running out ends the run
  task automatic wait_en(input logic [11:0] m, input int bound, output int t);
    int n;
    n = 0;
    while (en_out !== m && n < bound)
    begin
      tick();
      n++;
    end
    t = now;
    cmp(27'(en_out), 27'(m), "enable pattern");
    if (en_out !== m)
      complete_run();
  endtask
  task automatic wait_for(input int b, input int bound);
    int n;
    n = 0;
    while (flags[b] !== 1'b1 && n < bound)
    begin
      tick();
      n++;
    end
    cmp(27'(flags[b]), 27'h1, "awaited flag");
    if (flags[b] !== 1'b1)
      complete_run();
  endtask
  task automatic set_delays(input logic rev);
    wr(8'h50, {dc[2][1:0], dc[1], dc[0]});
    wr(8'h51, {dc[5][0], dc[4], dc[3], dc[2][2]});
    wr(8'h52, {dc[7], dc[6], dc[5][2:1]});
    wr(8'h53, {dc[10][1:0], dc[9], dc[8]});
    wr(8'h54, {3'h7, rev, dc[11], dc[10][2]});
  endtask
  task automatic map_slots;
    for (int i = 0; i < 6; i++) wr(8'h5e + 8'(i), {4'(2*i+2), 4'(2*i+1)});
  endtask

  initial
  begin
    {failures, checks_done, cfg_we, power_enable, cfg_addr, cfg_wdata} = '0;
    {hold_low, vacant} = '0;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    // Reset values, write back, dropped bits and unmapped places
    for (int a = 8'h4e; a <= 8'h63; a++) rd(8'(a), 8'h00);
    for (int a = 8'h4e; a <= 8'h63; a++) wr(8'(a), 8'hff);
    for (int a = 8'h4e; a <= 8'h63; a++)
      rd(8'(a), (a > 8'h54 && a < 8'h5e) ? 8'h00 : (a == 8'h54 ? 8'h1f : 8'hff));
    $display("test registers done");
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h4e, 8'((8'h10 << c) | (c << 2)));
      wr(8'h4f, 8'((c << 6) | (c << 4)));
      tick(2);
      cmp(27'(pulldown_en), 27'h1 << c, "pulldown enables");
      cmp(pd_timeout_cyc, TMO[c], "power-down timeout");
      cmp(27'(slew_vps), 27'h320 >> c, "slew rate");
      cmp(27'(deglitch_conv), 27'h2 << c, "deglitch count");
    end
    $display("test decodes done");
    // Full power-up, then reverse power-down
    map_slots();
    set_delays(1'b1);
    power_enable = 1'b1;
    for (int s = 0; s < 12; s++) wait_en(12'hfff >> (11 - s), 200, t_up[s]);
    wait_for(0, 200);
    cmp(27'(cur_slot), 27'hc, "power-on slot");
    for (int s = 2; s < 12; s++)
    begin
      k = t_up[s] - t_up[s-1] - t_up[2] + t_up[1];
      cmp(27'(k), DLY[dc[s]] - DLY[dc[2]], "up gap");
    end
    k = t_up[1] - t_up[0] - int'(DLY[dc[0]]) - int'(DLY[dc[1]]);
    t0 = t_up[2] - t_up[1] - int'(DLY[dc[2]]);
    cmp(27'(k >= 0 && k <= t0), 27'h1, "slot 0 delay");
    power_enable = 1'b0;
    for (int s = 11; s >= 0; s--) wait_en(12'hfff >> (12 - s), 200, t_dn[s]);
    for (int s = 11; s > 0; s--)
      cmp(27'(t_dn[s-1] - t_dn[s]), DLY[dc[s]], "down gap");
    tick(60);
    $display("test sequence done");
    // Unassigned and reserved codes, simultaneous power-down
    wr(8'h5e, 8'hd0);
    wr(8'h5f, 8'hfe);
    vacant = 12'h00f;
    set_delays(1'b0);
    power_enable = 1'b1;
    wait_for(0, 1500);
    cmp(27'(en_out), 27'hff0, "unassigned outputs");
    power_enable = 1'b0;
    tick();
    cmp(27'(en_out), 27'h0, "simultaneous off");
    tick(60);
    $display("test simultaneous done");
    // Power-up timeout with latch-off, then autoretry
    map_slots();
    vacant = 12'h000;
    hold_low = 13'h0002;
    for (int c = 0; c < 4; c += 3)
    begin
      wr(8'h4e, 8'(c));
      wr(8'h4f, 8'h08);
      power_enable = 1'b1;
      wait_en(12'h001, 20, t0);
      wait_for(1, 200);
      t_dn[c] = now - t0 - int'(TMO[c]);
      tick(2);
      cmp(27'(fault_latched), 27'h1, "latched");
      tick(40);
      cmp(27'(en_out), 27'h0, "restart refused");
      power_enable = 1'b0;
      tick(2);
      cmp(27'(fault_latched), 27'h0, "latch cleared");
      tick(4);
    end
    cmp(27'(t_dn[3] - t_dn[0]), 27'h0, "power-up timeout");
    wr(8'h4f, 8'h07);
    power_enable = 1'b1;
    wait_for(1, 200);
    t0 = now;
    wait_en(12'h000, 10, k);
    wait_en(12'h001, 100, k);
    cmp(27'(k - t0 >= 44 && k - t0 <= 56), 27'h1, "autoretry time");
    power_enable = 1'b0;
    hold_low = 13'h0000;
    tick(4);
    $display("test faults done");
    complete_run();
  end
endmodule
